// ### css_pkg.sv
// constants, operation codes and cycle numbers for the chebyshev sine sequencer
// assumes the processor runs on the same clock as the sequencer
package css_pkg;

    // ------------------------------------------------------------------
    // pin field widths and fixed settings
    // ------------------------------------------------------------------
    localparam int          HALF_W       = 32;
    localparam int          CYC_W        = 6;
    localparam int          WAIT_W       = 3;
    localparam logic [1:0]  RND_DEFAULT  = 2'h0;
    localparam logic [1:0]  RND_TRUNCATE_OP    = 2'h1;
    localparam logic [2:0]  PIPE_CFG     = 3'h2;
    // extra cycles spent on the external compare decision
    localparam logic [2:0]  DECIDE_WAIT  = 3'h5;

    // ------------------------------------------------------------------
    // sequence cycle numbers
    // ------------------------------------------------------------------
    localparam logic [5:0] CYC_IDLE     = 6'h00;
    localparam logic [5:0] CYC_X        = 6'h01;
    localparam logic [5:0] CYC_TWO_PI   = 6'h02;
    localparam logic [5:0] CYC_ADD1_A   = 6'h03;
    localparam logic [5:0] CYC_ONE_A    = 6'h04;
    localparam logic [5:0] CYC_QUARTER  = 6'h05;
    localparam logic [5:0] CYC_TRUNCATE_OP_A  = 6'h06;
    localparam logic [5:0] CYC_TRUNCATE_OP_B  = 6'h07;
    localparam logic [5:0] CYC_TIMES4   = 6'h08;
    localparam logic [5:0] CYC_TO_DBL   = 6'h09;
    localparam logic [5:0] CYC_SUB      = 6'h0A;
    localparam logic [5:0] CYC_CMP      = 6'h0B;
    localparam logic [5:0] CYC_DECIDE   = 6'h0C;
    localparam logic [5:0] CYC_FOLD     = 6'h0D;
    localparam logic [5:0] CYC_SQUARE   = 6'h0E;
    localparam logic [5:0] CYC_TIMES2_A = 6'h0F;
    localparam logic [5:0] CYC_TIMES2_B = 6'h10;
    localparam logic [5:0] CYC_MINUS_A  = 6'h11;
    localparam logic [5:0] CYC_NEG_ONE  = 6'h12;
    localparam logic [5:0] CYC_C8       = 6'h13;
    localparam logic [5:0] CYC_CORE_LO  = 6'h14;
    localparam logic [5:0] CYC_CORE_HI  = 6'h2A;
    localparam logic [5:0] CYC_COEF_LO  = 6'h15;
    localparam logic [5:0] CYC_COEF_OFS = 6'h12;
    localparam logic [5:0] CYC_FINAL    = 6'h2B;
    localparam logic [5:0] CYC_DUMMY    = 6'h2C;
    localparam logic [5:0] CYC_RES_HI   = 6'h2D;
    localparam logic [5:0] CYC_RES_LO   = 6'h2E;
    localparam logic [5:0] CORE_STRIDE  = 6'h03;
    localparam logic [5:0] CORE_MUL_PH  = 6'h02;

    // ------------------------------------------------------------------
    // instruction codes on the instruction port (encoding is local)
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_MUL_RA_RB = 4'h1,
        OP_ADD_PR_RB = 4'h2,
        OP_MUL_SR_RB = 4'h3,
        OP_DBL_TO_INT= 4'h4,
        OP_INT_TO_DBL= 4'h5,
        OP_SUB_CR_SR = 4'h6,
        OP_COMPARE   = 4'h7,
        OP_SUB_RB_CR = 4'h8,
        OP_PASS_CR   = 4'h9,
        OP_MUL_CR_CR = 4'hA,
        OP_MUL_RA_PR = 4'hB,
        OP_MUL_SR_CR = 4'hC,
        OP_DUMMY     = 4'hD
    } css_op_t;

    // operand sources for the two input buses
    typedef enum logic [3:0] {
        OPD_NONE    = 4'h0,
        OPD_X       = 4'h1,
        OPD_TWO_PI  = 4'h2,
        OPD_ONE     = 4'h3,
        OPD_QUARTER = 4'h4,
        OPD_INT4    = 4'h5,
        OPD_TWO     = 4'h6,
        OPD_NEG_ONE = 4'h7,
        OPD_COEF    = 4'h8,
        OPD_FOLD    = 4'h9
    } css_opd_t;

    // ------------------------------------------------------------------
    // double precision constants and the integer four
    // ------------------------------------------------------------------
    localparam logic [63:0] DP_TWO_PI  = 64'h3FE45F306DC9C883;
    localparam logic [63:0] DP_ONE     = 64'h3FF0000000000000;
    localparam logic [63:0] DP_QUARTER = 64'h3FD0000000000000;
    localparam logic [63:0] DP_TWO     = 64'h4000000000000000;
    localparam logic [63:0] DP_NEG_ONE = 64'hBFF0000000000000;
    localparam logic [63:0] INT_FOUR   = 64'h0000000000000004;
    localparam int          N_COEF     = 9;
    // index 0 is the highest order term
    localparam logic [63:0] COEF [N_COEF] = '{
        64'h3D19D46B7D4C8F32, 64'hBD962909C5C01ED6, 64'h3E0D53517735F927,
        64'hBE7CC930FD0ADA9D, 64'h3EE3E0AF61F7677F, 64'hBF41E5FDEF25C403,
        64'h3F92A9FB40C119ED, 64'hBFD23B03366AA0C9, 64'h3FF4464BCC8CBA1F
    };

endpackage : css_pkg

// ### css_const_rom.sv
// operand constant table for the sine sequencer
// assumes x and the folded value are supplied by the caller
`timescale 1ns/1ps
module css_const_rom (
    input  wire logic [3:0]  i_sel,
    input  wire logic [3:0]  i_coef_idx,
    input  wire logic [63:0] i_x,
    input  wire logic [63:0] i_fold,
    output logic      [63:0] o_value
);

    // ------------------------------------------------------------------
    // selection
    // ------------------------------------------------------------------
    // out of range coefficient index gives zero, never reached in sequence
    wire        coef_ok = (i_coef_idx < 4'(css_pkg::N_COEF));
    wire [63:0] coef_v  = coef_ok ? css_pkg::COEF[i_coef_idx] : 64'h0;

    always_comb begin
        case (css_pkg::css_opd_t'(i_sel))
            css_pkg::OPD_X:       o_value = i_x;
            css_pkg::OPD_TWO_PI:  o_value = css_pkg::DP_TWO_PI;
            css_pkg::OPD_ONE:     o_value = css_pkg::DP_ONE;
            css_pkg::OPD_QUARTER: o_value = css_pkg::DP_QUARTER;
            css_pkg::OPD_INT4:    o_value = css_pkg::INT_FOUR;
            css_pkg::OPD_TWO:     o_value = css_pkg::DP_TWO;
            css_pkg::OPD_NEG_ONE: o_value = css_pkg::DP_NEG_ONE;
            css_pkg::OPD_COEF:    o_value = coef_v;
            css_pkg::OPD_FOLD:    o_value = i_fold;
            default:              o_value = 64'h0;
        endcase
    end

endmodule : css_const_rom

// ### css_sequencer.sv
// sequencer that drives the floating point processor through the sine routine
// assumes the processor shares i_clk and answers on the y bus with fixed latency
// Operation
// - input is radians; values handled are 64-bit double precision except the integer four.
// - reduced value above 1.0 folds to 2.0 minus it, else kept.
// - rounding control truncates during the two conversion cycles, else default.
// - pipeline configuration stays fixed at 010 for the whole sequence.
// - two over pi constant presented right after the input value.
// - controller reads compare outcome and picks subtract or pass path.
// - one no-operation after compare, then exactly one of two alternatives; the sequencer issues six no-operations there.
// - folded value appears on y bus two cycles; controller captures it.
// - controller stores folded value and feeds it back for final multiply.
// - sequence takes 46 device cycles plus five decision cycles.
// - nine fixed coefficient patterns supplied from highest to constant term.
`timescale 1ns/1ps
module css_sequencer (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // user side
    input  wire logic        i_start,
    input  wire logic [63:0] i_x,
    output logic             o_busy,
    output logic             o_done,
    output logic      [63:0] o_result,
    // processor side
    output logic      [31:0] o_da,
    output logic      [31:0] o_db,
    output logic      [3:0]  o_instr,
    output logic             o_clk_mode,
    output logic      [1:0]  o_rounding_control,
    output logic      [2:0]  o_pipeline_configuration,
    input  wire logic [31:0] i_y,
    input  wire logic        i_compare_gt
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [5:0]  cyc_q;      // cycle being decoded
    logic [5:0]  cur_q;      // cycle now shown on the pins
    logic [2:0]  wait_q;
    logic        run_q;
    logic        fold_q;
    logic [63:0] x_q;
    logic [63:0] fold_val_q;
    logic [63:0] res_q;
    logic        done_q;

    // ------------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------------
    wire [5:0] core_off  = cyc_q - css_pkg::CYC_CORE_LO;
    wire [5:0] core_ph   = core_off % css_pkg::CORE_STRIDE;
    wire       in_core   = (cyc_q >= css_pkg::CYC_CORE_LO) && (cyc_q <= css_pkg::CYC_CORE_HI);
    wire [5:0] coef_off  = cyc_q - css_pkg::CYC_COEF_LO;
    wire       coef_slot = (cyc_q == css_pkg::CYC_C8) ||
                           (in_core && (cyc_q >= css_pkg::CYC_COEF_LO) &&
                            ((coef_off % css_pkg::CORE_STRIDE) == 6'h00));
    wire [5:0] coef_idx6 = (cyc_q - css_pkg::CYC_COEF_OFS) / css_pkg::CORE_STRIDE;
    wire [3:0] coef_idx  = coef_idx6[3:0];
    wire       core_mul  = in_core && (core_ph == css_pkg::CORE_MUL_PH);
    wire       in_wait   = (cyc_q == css_pkg::CYC_DECIDE) && (wait_q < css_pkg::DECIDE_WAIT);

    // instruction for a cycle; the fold choice picks one alternative only
    function automatic css_pkg::css_op_t op_of(input logic [5:0] c, input logic f,
                                               input logic cm, input logic ic);
        css_pkg::css_op_t r;
        r = css_pkg::OP_NOP;
        case (c)
            css_pkg::CYC_X, css_pkg::CYC_TWO_PI:       r = css_pkg::OP_MUL_RA_RB;
            css_pkg::CYC_ADD1_A, css_pkg::CYC_ONE_A:   r = css_pkg::OP_ADD_PR_RB;
            css_pkg::CYC_QUARTER, css_pkg::CYC_TIMES4: r = css_pkg::OP_MUL_SR_RB;
            css_pkg::CYC_TRUNCATE_OP_A, css_pkg::CYC_TRUNCATE_OP_B: r = css_pkg::OP_DBL_TO_INT;
            css_pkg::CYC_TO_DBL:   r = css_pkg::OP_INT_TO_DBL;
            css_pkg::CYC_SUB:      r = css_pkg::OP_SUB_CR_SR;
            css_pkg::CYC_CMP:      r = css_pkg::OP_COMPARE;
            css_pkg::CYC_DECIDE:   r = css_pkg::OP_NOP;
            css_pkg::CYC_FOLD:     r = f ? css_pkg::OP_SUB_RB_CR : css_pkg::OP_PASS_CR;
            css_pkg::CYC_SQUARE:   r = css_pkg::OP_MUL_CR_CR;
            css_pkg::CYC_TIMES2_A, css_pkg::CYC_TIMES2_B: r = css_pkg::OP_MUL_RA_PR;
            css_pkg::CYC_MINUS_A, css_pkg::CYC_NEG_ONE:   r = css_pkg::OP_ADD_PR_RB;
            css_pkg::CYC_C8:       r = css_pkg::OP_MUL_SR_RB;
            css_pkg::CYC_FINAL:    r = css_pkg::OP_MUL_SR_RB;
            css_pkg::CYC_DUMMY:    r = css_pkg::OP_DUMMY;
            default: begin
                if (ic) begin
                    r = cm ? css_pkg::OP_MUL_SR_CR : css_pkg::OP_ADD_PR_RB;
                end
            end
        endcase
        return r;
    endfunction : op_of

    // operand source per cycle
    function automatic css_pkg::css_opd_t opd_of(input logic [5:0] c, input logic f,
                                                 input logic cs);
        css_pkg::css_opd_t r;
        r = css_pkg::OPD_NONE;
        case (c)
            css_pkg::CYC_X:        r = css_pkg::OPD_X;
            css_pkg::CYC_TWO_PI:   r = css_pkg::OPD_TWO_PI;
            css_pkg::CYC_ONE_A, css_pkg::CYC_TRUNCATE_OP_A: r = css_pkg::OPD_ONE;
            css_pkg::CYC_QUARTER:  r = css_pkg::OPD_QUARTER;
            css_pkg::CYC_TIMES4:   r = css_pkg::OPD_INT4;
            css_pkg::CYC_FOLD:     r = f ? css_pkg::OPD_TWO : css_pkg::OPD_NONE;
            css_pkg::CYC_TIMES2_A: r = css_pkg::OPD_TWO;
            css_pkg::CYC_NEG_ONE:  r = css_pkg::OPD_NEG_ONE;
            css_pkg::CYC_FINAL:    r = css_pkg::OPD_FOLD;
            default: begin
                if (cs) begin
                    r = css_pkg::OPD_COEF;
                end
            end
        endcase
        return r;
    endfunction : opd_of

    wire css_pkg::css_op_t  op_d  = run_q ? op_of(cyc_q, fold_q, core_mul, in_core)
                                          : css_pkg::OP_NOP;
    wire css_pkg::css_opd_t opd_d = run_q ? opd_of(cyc_q, fold_q, coef_slot)
                                          : css_pkg::OPD_NONE;
    // clock mode high on cycles that end a two-step operation
    wire cm_d = run_q && !in_wait &&
                ((cyc_q == css_pkg::CYC_QUARTER) || (cyc_q == css_pkg::CYC_TO_DBL) ||
                 (cyc_q == css_pkg::CYC_SUB) || (cyc_q == css_pkg::CYC_CMP) ||
                 (cyc_q == css_pkg::CYC_FOLD) || (cyc_q == css_pkg::CYC_SQUARE) ||
                 (cyc_q == css_pkg::CYC_C8) || (cyc_q == css_pkg::CYC_FINAL) || core_mul);
    wire truncate_op_d = run_q && ((cyc_q == css_pkg::CYC_TRUNCATE_OP_A) ||
                             (cyc_q == css_pkg::CYC_TRUNCATE_OP_B));
    wire [1:0] rnd_d = truncate_op_d ? css_pkg::RND_TRUNCATE_OP : css_pkg::RND_DEFAULT;

    wire [63:0] operand;
    css_const_rom u_rom (
        .i_sel      (opd_d),
        .i_coef_idx (coef_idx),
        .i_x        (x_q),
        .i_fold     (fold_val_q),
        .o_value    (operand)
    );

    // ------------------------------------------------------------------
    // cycle counter; holds at the decision nop for the external choice
    // ------------------------------------------------------------------
    wire start_ok = i_start && !o_busy;
    wire last     = (cyc_q == css_pkg::CYC_RES_LO);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            run_q  <= 1'b0;
            cyc_q  <= css_pkg::CYC_IDLE;
            wait_q <= 3'h0;
        end else if (start_ok) begin
            run_q  <= 1'b1;
            cyc_q  <= css_pkg::CYC_X;
            wait_q <= 3'h0;
        end else if (run_q) begin
            if (in_wait) begin
                wait_q <= wait_q + 3'h1;
            end else if (last) begin
                run_q <= 1'b0;
                cyc_q <= css_pkg::CYC_IDLE;
            end else begin
                cyc_q <= cyc_q + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered pins
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_da               <= 32'h0;
            o_db               <= 32'h0;
            o_instr            <= css_pkg::OP_NOP;
            o_clk_mode         <= 1'b0;
            o_rounding_control <= css_pkg::RND_DEFAULT;
            cur_q              <= css_pkg::CYC_IDLE;
        end else begin
            o_da               <= operand[63:32];
            o_db               <= operand[31:0];
            o_instr            <= op_d;
            o_clk_mode         <= cm_d;
            o_rounding_control <= rnd_d;
            cur_q              <= run_q ? cyc_q : css_pkg::CYC_IDLE;
        end
    end

    // fixed for the whole routine; it sets each result's latency
    assign o_pipeline_configuration = css_pkg::PIPE_CFG;

    // ------------------------------------------------------------------
    // captures from the device: compare outcome, folded value, result
    // ------------------------------------------------------------------
    // compare sampled on the cycle after the last wait cycle so the device has time to settle
    wire take_cmp = run_q && (cyc_q == css_pkg::CYC_DECIDE) &&
                    (wait_q == css_pkg::DECIDE_WAIT);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            x_q        <= 64'h0;
            fold_q     <= 1'b0;
            fold_val_q <= 64'h0;
            res_q      <= 64'h0;
            done_q     <= 1'b0;
        end else begin
            if (start_ok) begin
                x_q <= i_x;
            end
            if (take_cmp) begin
                fold_q <= i_compare_gt;
            end
            if (cur_q == css_pkg::CYC_SQUARE) begin
                fold_val_q[63:32] <= i_y;
            end
            if (cur_q == css_pkg::CYC_TIMES2_A) begin
                fold_val_q[31:0] <= i_y;
            end
            if (cur_q == css_pkg::CYC_RES_HI) begin
                res_q[63:32] <= i_y;
            end
            if (cur_q == css_pkg::CYC_RES_LO) begin
                res_q[31:0] <= i_y;
            end
            done_q <= (cur_q == css_pkg::CYC_RES_LO);
        end
    end

    assign o_result = res_q;
    assign o_done   = done_q;
    assign o_busy   = run_q || (cur_q != css_pkg::CYC_IDLE) || done_q;

endmodule : css_sequencer

// ### css_sequencer_assertions.sv
// checker for the sine sequencer's processor-side pins
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module css_sequencer_checker (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_start,
    input wire logic [63:0] i_x,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [63:0] o_result,
    input wire logic [31:0] o_da,
    input wire logic [31:0] o_db,
    input wire logic [3:0]  o_instr,
    input wire logic        o_clk_mode,
    input wire logic [1:0]  o_rounding_control,
    input wire logic [2:0]  o_pipeline_configuration,
    input wire logic [31:0] i_y,
    input wire logic        i_compare_gt
);
    // ----
    // decoded conditions
    // ----
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // accepted start, the alternative step and the conversion step
    wire        take = i_start && !o_busy;
    wire        alt  = o_instr == css_pkg::OP_SUB_RB_CR || o_instr == css_pkg::OP_PASS_CR;
    wire        cvt  = o_instr == css_pkg::OP_DBL_TO_INT;
    wire [63:0] opd  = {o_da, o_db};

    // ----
    // assertions
    // ----
    pipe_fixed_a: assert property (o_pipeline_configuration == css_pkg::PIPE_CFG)
        else $error("pipeline setting moved");
    round_mode_a: assert property (o_rounding_control == (cvt ? 2'h1 : 2'h0))
        else $error("rounding control wrong");
    truncate_op_pair_a: assert property ($rose(cvt) |=> cvt ##1 !cvt)
        else $error("conversion not two cycles");
    operand_order_a: assert property (take |-> ##2 opd == $past(i_x, 2) ##1
        opd == css_pkg::DP_TWO_PI) else $error("input or constant misplaced");
    one_choice_a: assert property (o_instr == css_pkg::OP_COMPARE |=>
        (o_instr == css_pkg::OP_NOP) [*6] ##1 ($past(i_compare_gt) ?
        (o_instr == css_pkg::OP_SUB_RB_CR && opd == css_pkg::DP_TWO) :
        o_instr == css_pkg::OP_PASS_CR)) else $error("wrong step after compare");
    coef_order_a: assert property (alt |-> ##6 opd == css_pkg::COEF[0] ##23
        opd == css_pkg::COEF[8]) else $error("coefficient misplaced");
    fold_return_a: assert property (alt |-> ##30
        opd == {$past(i_y, 29), $past(i_y, 28)}) else $error("folded value not returned");
    result_read_a: assert property (o_instr == css_pkg::OP_DUMMY |-> ##3
        o_done && o_result == {$past(i_y, 2), $past(i_y, 1)}) else $error("result halves wrong");
    done_time_a: assert property (take |-> !o_done [*8] ##46 o_done ##1 !o_done)
        else $error("done not at fixed latency");
    // core multiplies and the alternative step end a two-step operation; idle cycles never do
    clk_mode_a: assert property ((o_instr == css_pkg::OP_MUL_SR_CR || alt) ? o_clk_mode :
        (o_instr != css_pkg::OP_NOP || !o_clk_mode)) else $error("clock mode wrong");

    // main scenarios reached
    fold_seen_c: cover property (o_instr == css_pkg::OP_SUB_RB_CR);
    pass_seen_c: cover property (o_instr == css_pkg::OP_PASS_CR);
    done_seen_c: cover property (o_done);
endmodule : css_sequencer_checker

bind css_sequencer css_sequencer_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_start(i_start), .i_x(i_x), .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
    .o_da(o_da), .o_db(o_db), .o_instr(o_instr), .o_clk_mode(o_clk_mode),
    .o_rounding_control(o_rounding_control),
    .o_pipeline_configuration(o_pipeline_configuration), .i_y(i_y),
    .i_compare_gt(i_compare_gt));

// ### css_fpu_model.sv
// behavioural model of the floating point processor running the sine steps
// assumes the sequencer's clock and the local instruction encoding
`timescale 1ns/1ps
module css_fpu_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [31:0] i_da,
    input  wire logic [31:0] i_db,
    input  wire logic [3:0]  i_instr,
    input  wire logic [1:0]  i_rounding_control,
    input  wire logic [2:0]  i_pipeline_configuration,
    output logic      [31:0] o_y,
    output logic             o_compare_gt
);
    real         x, tpi, x1, x2, x3, x4, acc, opd;
    logic [63:0] out_q;
    logic        bad, poly, folded, lo_next;
    int          k;
    // ----
    // one decoded instruction per clock
    // ----
    always @(posedge i_clk) begin
        opd = $bitstoreal({i_da, i_db});
        if (!i_rst_n) begin
            k = 0; bad = 1'b0; poly = 1'b0; folded = 1'b0; lo_next = 1'b0;
            o_y <= 32'h0;
            o_compare_gt <= 1'b0;
        end else begin
            // a released bus never keeps its last word
            o_y <= lo_next ? out_q[31:0] : ~o_y;
            lo_next = 1'b0;
            // wrong settings poison the answer instead of passing silently
            if (i_pipeline_configuration != css_pkg::PIPE_CFG) bad = 1'b1;
            if (i_instr == css_pkg::OP_DBL_TO_INT ^ i_rounding_control == css_pkg::RND_TRUNCATE_OP)
                bad = 1'b1;
            case (i_instr)
                css_pkg::OP_MUL_RA_RB: begin
                    if (k == 0) x = opd;
                    else tpi = opd;
                    k++;
                end
                css_pkg::OP_COMPARE: begin
                    x1 = x * tpi;
                    x2 = x1 - 4.0 * $rtoi(0.25 * (x1 + 1.0));
                    o_compare_gt <= x2 > 1.0;
                end
                css_pkg::OP_SUB_RB_CR, css_pkg::OP_PASS_CR: begin
                    x3 = (i_instr == css_pkg::OP_PASS_CR) ? x2 : opd - x2;
                    x4 = 2.0 * (x3 * x3) - 1.0;
                    out_q = $realtobits(x3);
                    o_y <= out_q[63:32];
                    lo_next = 1'b1;
                    folded = 1'b1;
                end
                css_pkg::OP_MUL_SR_RB: if (folded) begin
                    acc = poly ? acc * opd : opd * x4;
                    poly = 1'b1;
                end
                css_pkg::OP_ADD_PR_RB: if (poly) acc = acc + opd;
                css_pkg::OP_MUL_SR_CR: if (poly) acc = acc * x4;
                css_pkg::OP_DUMMY: begin
                    out_q = $realtobits(acc) ^ {63'h0, bad};
                    o_y <= out_q[63:32];
                    lo_next = 1'b1;
                    k = 0; poly = 1'b0; folded = 1'b0; bad = 1'b0;
                end
                default: ;
            endcase
        end
    end
endmodule : css_fpu_model

// ### css_sequencer_tb.sv
// self-checking bench for the sine sequencer against the processor model
// assumes the checker is bound to the sequencer by its own file
`timescale 1ns/1ps
`define CSS_CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module css_sequencer_tb;
    logic        i_clk, i_rst_n, i_start, o_busy, o_done, o_clk_mode, i_compare_gt;
    logic [63:0] i_x, o_result;
    logic [31:0] o_da, o_db, i_y;
    logic [3:0]  o_instr;
    logic [1:0]  o_rounding_control;
    logic [2:0]  o_pipeline_configuration;
    int          err_count = 0;
    int          compares  = 0;

    css_sequencer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_x(i_x),
        .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_da(o_da), .o_db(o_db),
        .o_instr(o_instr), .o_clk_mode(o_clk_mode), .o_rounding_control(o_rounding_control),
        .o_pipeline_configuration(o_pipeline_configuration), .i_y(i_y),
        .i_compare_gt(i_compare_gt));
    css_fpu_model u_fpu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_da(o_da), .i_db(o_db),
        .i_instr(o_instr), .i_rounding_control(o_rounding_control),
        .i_pipeline_configuration(o_pipeline_configuration), .o_y(i_y),
        .o_compare_gt(i_compare_gt));

    // 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // ----
    // reference and shared tasks
    // ----
    function automatic logic [63:0] sin_ref(input logic [63:0] xb);
        real x1, x2, x3, x4, a;
        x1 = $bitstoreal(xb) * $bitstoreal(css_pkg::DP_TWO_PI);
        x2 = x1 - 4.0 * $rtoi(0.25 * (x1 + 1.0));
        x3 = (x2 > 1.0) ? 2.0 - x2 : x2;
        x4 = 2.0 * (x3 * x3) - 1.0;
        a  = $bitstoreal(css_pkg::COEF[0]);
        for (int i = 1; i < 9; i++) a = a * x4 + $bitstoreal(css_pkg::COEF[i]);
        return $realtobits(a * x3);
    endfunction : sin_ref

    task automatic end_sim();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic start_op(input logic [63:0] x);
        @(negedge i_clk);
        i_start = 1'b1;
        i_x     = x;
        @(negedge i_clk);
        i_start = 1'b0;
    endtask : start_op

    // waits for done with a bound; n counts clocks from the call
    task automatic wait_done(input logic [63:0] x, input int exp_n);
        int n;
        n = 0;
        while (o_done !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 200) begin
            err_count++;
            end_sim();
        end else begin
            `CSS_CHK(n, exp_n)
            `CSS_CHK(o_result, sin_ref(x))
        end
    endtask : wait_done

    // ----
    // scenarios
    // ----
    task automatic t_reset_state();
        `CSS_CHK(o_pipeline_configuration, css_pkg::PIPE_CFG)
        `CSS_CHK({o_busy, o_done, o_instr, o_rounding_control}, 8'h00)
    endtask : t_reset_state

    task automatic t_pass_path();
        start_op(64'h3FE0000000000000);
        wait_done(64'h3FE0000000000000, 52);
    endtask : t_pass_path

    // a second start while busy is ignored
    task automatic t_fold_refused();
        start_op(64'h4004000000000000);
        repeat (9) @(negedge i_clk);
        start_op(64'hBFF0000000000000);
        wait_done(64'h4004000000000000, 41);
    endtask : t_fold_refused

    task automatic t_back_to_back();
        start_op(64'hBFF0000000000000);
        wait_done(64'hBFF0000000000000, 52);
        start_op(64'h4024000000000000);
        wait_done(64'h4024000000000000, 52);
    endtask : t_back_to_back

    // reset mid-frame must leave a clean machine
    task automatic t_reset_midrun();
        start_op(64'h4024000000000000);
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        `CSS_CHK({o_busy, o_instr, o_da}, 37'h0)
        start_op(64'h3FF921FB54442D18);
        wait_done(64'h3FF921FB54442D18, 52);
    endtask : t_reset_midrun

    initial begin
        i_rst_n = 1'b0;
        i_start = 1'b0;
        i_x     = 64'h0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_reset_state();
        t_pass_path();
        t_fold_refused();
        t_back_to_back();
        t_reset_midrun();
        end_sim();
    end
endmodule : css_sequencer_tb
